// >>> hw/spi_mem_pkg.sv
// Shared constants, opcodes, timings and types for the serial memory link
package spi_mem_pkg;

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int MCLK_MHZ = 250;

  // ----------------------------------------------------------------
  // Instruction codes and phase lengths in bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h42;
  localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_ALT = 8'hc7;
  localparam logic [7:0] OP_READ_OTP = 8'h77;
  localparam logic [7:0] OP_DEEP_DOWN = 8'h79;
  localparam logic [7:0] OP_RESUME = 8'hab;
  localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
  localparam logic [5:0] RD_START_NONE = 6'h00;
  localparam logic [5:0] RD_START_STATUS = 6'h01;
  localparam logic [5:0] RD_START_READ = 6'h03;
  localparam logic [5:0] RD_START_FAST = 6'h04;
  localparam logic [5:0] WR_ONE_BYTE = 6'h04;
  localparam logic [5:0] ERASE_LEN = 6'h03;
  localparam logic [5:0] NBYTE_MAX = 6'h3f;
  localparam int BUSY_FLAG_BIT = 0;

  // ----------------------------------------------------------------
  // Internal write cycle times (typical figures)
  // ----------------------------------------------------------------
  localparam int BYTE_WR_US = 60;
  localparam int BYTE_WR_CYC = BYTE_WR_US * MCLK_MHZ;
  localparam real PAGE_WR_MS = 1.5;
  localparam int PAGE_WR_CYC = int'(PAGE_WR_MS * 1000.0 * MCLK_MHZ);
  localparam int BUSY_W = 20;

  // ----------------------------------------------------------------
  // Master side clock rates and wait times
  // ----------------------------------------------------------------
  localparam real SCK_NORMAL_MHZ = 1.6;
  localparam real SCK_FAST_MHZ = 10.0;
  localparam real SCK_APD_MHZ = 1.0;
  localparam int HALF_NORMAL = int'($ceil(MCLK_MHZ / (2.0 * SCK_NORMAL_MHZ)));
  localparam int HALF_FAST = int'($ceil(MCLK_MHZ / (2.0 * SCK_FAST_MHZ)));
  localparam int HALF_APD = int'($ceil(MCLK_MHZ / (2.0 * SCK_APD_MHZ)));
  localparam int RESUME_US = 50;
  localparam int RESUME_CYC = RESUME_US * MCLK_MHZ;
  localparam int DEEP_EXIT_US = 70;
  localparam int DEEP_EXIT_CYC = DEEP_EXIT_US * MCLK_MHZ;
  localparam int CS_MIN_NS = 100;
  localparam int CS_MIN_CYC = (CS_MIN_NS * MCLK_MHZ + 999) / 1000;
  localparam int CNT_W = 15;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RATE_NORMAL, RATE_FAST, RATE_AUTO_PD} rate_t;
  typedef enum logic [2:0] {
    M_IDLE, M_WAKE, M_GUARD, M_SETUP, M_LOW, M_HIGH, M_END, M_GAP
  } mstate_t;

endpackage

// >>> hw/spi_mem_if.sv
// Serial link between the memory device and its master
`timescale 1ns/10ps
interface spi_mem_if;
  // Master driven lines
  logic cs_n;
  logic sck;
  logic sdi;
  logic hold_n;
  // Device output pin pieces
  logic sdo_o;
  logic sdo_oe_n;
  logic sdo_pu;
  // Resolved output line
  logic sdo;

  // Driven value, else pull-up, else inverse of the last bit as a float
  assign sdo = !sdo_oe_n ? sdo_o : (sdo_pu | !sdo_o);

  modport dev (
    input cs_n,
    input sck,
    input sdi,
    input hold_n,
    output sdo_o,
    output sdo_oe_n,
    output sdo_pu
  );

  modport host (
    output cs_n,
    output sck,
    output sdi,
    output hold_n,
    input sdo
  );
endinterface

// >>> hw/spi_mem_device.sv
// Device end: serial slave front end of the memory
//
// How it works
// - Input bits taken on serial clock rise.
// - Output bits shifted on serial clock fall.
// - Select low activates, high returns to standby.
// - Deselected: input ignored, output floating.
// - Output pull-up only in ultra-deep power-down.
// - Hold low pauses transfer, shift state kept.
// - Only modes 0 and 3 supported.
// - Master parks clock per mode while deselected.
// - Fast read clock at most 10 MHz.
// - Normal read clock at most 1.6 MHz; the bench runs OP_READ at the fast rate.
// - Auto power-down clock at most 1.0 MHz.
// - Page write cycle 1.5 ms typical.
// - Byte write cycle 60 us typical.
// - Master waits 50/70 us after wake-up.
// - Standby reached within 8 us of deselect.
// - Master keeps its lines at valid levels.
// - Bytes MSB first from first rise.
// - Busy flag bit 0 while write runs.
`timescale 1ns/10ps
module spi_mem_device #(
  parameter int BYTE_WR_CYCLES = spi_mem_pkg::BYTE_WR_CYC,
  parameter int PAGE_WR_CYCLES = spi_mem_pkg::PAGE_WR_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Serial link
  spi_mem_if.dev link,
  // Received byte stream
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_first,
  // Read data supply
  output logic tx_req,
  input wire logic [7:0] tx_data,
  // Status and power
  input wire logic [7:1] status_upper,
  output logic write_busy_flag,
  output logic active,
  output logic standby,
  output logic power_down,
  output logic deep_power_down,
  output logic frame_end,
  output logic frame_abort
);
  import spi_mem_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sel_s1;
    logic sel_s2;
    logic sel_q;
    logic sck_s1;
    logic sck_s2;
    logic sck_q;
    logic sdi_s1;
    logic sdi_s2;
    logic held_s1;
    logic held_s2;
    logic [2:0] bitc;
    logic [7:0] rxsr;
    logic [5:0] nbyte;
    logic [7:0] op;
    logic [7:0] txsr;
    logic sdo;
    logic drive;
    logic [BUSY_W-1:0] btimer;
    logic pd;
    logic udpd;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_first;
    logic tx_req;
    logic frame_end;
    logic frame_abort;
  } dev_st_t;

  dev_st_t s;
  dev_st_t next_s;
  logic busy;
  logic sck_rise;
  logic sck_fall;
  logic taking;
  logic [5:0] start_cur;

  // Byte index at which read data begins, none for other commands
  function automatic logic [5:0] rd_start(input logic [7:0] op);
    unique case (op)
      OP_READ: rd_start = RD_START_READ;
      OP_FAST_READ: rd_start = RD_START_FAST;
      OP_READ_STATUS: rd_start = RD_START_STATUS;
      OP_READ_OTP: rd_start = RD_START_STATUS;
      default: rd_start = RD_START_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Decoded strobes
  // ----------------------------------------------------------------
  assign busy = (s.btimer != '0);
  assign sck_rise = s.sck_s2 & !s.sck_q;
  assign sck_fall = !s.sck_s2 & s.sck_q;
  assign taking = s.sel_s2 & !s.held_s2 & !s.udpd;
  assign start_cur = rd_start(s.op);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] byte_in;
    logic [7:0] opv;
    logic [7:0] load;
    logic [5:0] st;
    byte_in = '0;
    opv = '0;
    load = '0;
    st = '0;
    next_s = s;
    next_s.rx_valid = 1'h0;
    next_s.tx_req = 1'h0;
    next_s.frame_end = 1'h0;
    next_s.frame_abort = 1'h0;
    // Two-stage synchronisers for the pins
    next_s.sel_s1 = !link.cs_n;
    next_s.sel_s2 = s.sel_s1;
    next_s.sel_q = s.sel_s2;
    next_s.sck_s1 = link.sck;
    next_s.sck_s2 = s.sck_s1;
    next_s.sck_q = s.sck_s2;
    next_s.sdi_s1 = link.sdi;
    next_s.sdi_s2 = s.sdi_s1;
    next_s.held_s1 = !link.hold_n;
    next_s.held_s2 = s.held_s1;
    // Internal write cycle timer
    if (busy)
    begin
      next_s.btimer = s.btimer - 1'h1;
    end
    // Frame start on select
    if (s.sel_s2 & !s.sel_q)
    begin
      next_s.bitc = 3'h0;
      next_s.nbyte = 6'h00;
      next_s.drive = 1'h0;
    end
    // Input shift on clock rise, MSB first
    if (taking & sck_rise)
    begin
      byte_in = {s.rxsr[6:0], s.sdi_s2};
      next_s.rxsr = byte_in;
      next_s.bitc = s.bitc + 3'h1;
      if (s.bitc == 3'h7)
      begin
        opv = (s.nbyte == 6'h00) ? byte_in : s.op;
        st = rd_start(opv);
        if (s.nbyte == 6'h00)
        begin
          next_s.op = byte_in;
        end
        if (s.nbyte != NBYTE_MAX)
        begin
          next_s.nbyte = s.nbyte + 6'h1;
        end
        next_s.rx_valid = !s.pd;
        next_s.rx_data = byte_in;
        next_s.rx_first = (s.nbyte == 6'h00);
        next_s.tx_req = !s.pd && (st != RD_START_NONE) &&
          (opv != OP_READ_STATUS) && (6'(s.nbyte + 6'h1) >= st);
      end
    end
    // Output shift on clock fall during a read phase
    if (taking & sck_fall & !s.pd & (start_cur != RD_START_NONE) &
        (s.nbyte >= start_cur))
    begin
      if (s.bitc == 3'h0)
      begin
        load = tx_data;
        if (s.op == OP_READ_STATUS)
        begin
          load = {status_upper, busy};
        end
        next_s.sdo = load[7];
        next_s.txsr = {load[6:0], 1'h0};
        next_s.drive = 1'h1;
      end
      else
      begin
        next_s.sdo = s.txsr[7];
        next_s.txsr = {s.txsr[6:0], 1'h0};
      end
    end
    // Frame end on deselect: run the command or drop it
    if (!s.sel_s2 & s.sel_q)
    begin
      next_s.frame_end = 1'h1;
      next_s.bitc = 3'h0;
      next_s.drive = 1'h0;
      if (s.udpd)
        next_s.udpd = 1'h0;
      else if (s.nbyte == 6'h00)
        next_s.frame_abort = (s.bitc != 3'h0);
      else if (s.pd)
        next_s.pd = (s.op != OP_RESUME);
      else
      begin
        unique case (s.op)
          OP_POWER_DOWN: next_s.pd = 1'h1;
          OP_DEEP_DOWN: next_s.udpd = 1'h1;
          OP_WRITE:
            if (!busy && s.nbyte == WR_ONE_BYTE)
              next_s.btimer = BUSY_W'(BYTE_WR_CYCLES);
            else if (!busy && s.nbyte > WR_ONE_BYTE)
              next_s.btimer = BUSY_W'(PAGE_WR_CYCLES);
          OP_PAGE_ERASE:
            if (!busy && s.nbyte >= ERASE_LEN)
              next_s.btimer = BUSY_W'(PAGE_WR_CYCLES);
          OP_CHIP_ERASE, OP_CHIP_ERASE_ALT:
            if (!busy)
              next_s.btimer = BUSY_W'(PAGE_WR_CYCLES);
          default:
          begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Pin drive only in a read phase, selected and not on hold
  assign link.sdo_o = s.sdo;
  assign link.sdo_oe_n = !(s.drive & s.sel_s2 & !s.held_s2);
  assign link.sdo_pu = s.udpd;
  assign rx_valid = s.rx_valid;
  assign rx_data = s.rx_data;
  assign rx_first = s.rx_first;
  assign tx_req = s.tx_req;
  assign write_busy_flag = busy;
  assign active = s.sel_s2 & !s.udpd;
  assign standby = !s.sel_s2 & !busy & !s.pd & !s.udpd;
  assign power_down = s.pd;
  assign deep_power_down = s.udpd;
  assign frame_end = s.frame_end;
  assign frame_abort = s.frame_abort;

endmodule

// >>> hw/spi_mem_master.sv
// Master end: drives frames of bytes onto the serial memory link
`timescale 1ns/10ps
module spi_mem_master #(
  parameter int RESUME_CYCLES = spi_mem_pkg::RESUME_CYC,
  parameter int DEEP_EXIT_CYCLES = spi_mem_pkg::DEEP_EXIT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Serial link
  spi_mem_if.host link,
  // Configuration
  input wire logic mode3,
  input wire spi_mem_pkg::rate_t rate_sel,
  input wire logic hold_req,
  // Outgoing bytes, first byte of a frame is the instruction
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  // Incoming bytes
  output logic rx_valid,
  output logic [7:0] rx_data,
  // Status
  output logic idle
);
  import spi_mem_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mstate_t st;
    logic sel;
    logic sck;
    logic sdi;
    logic held;
    logic sdo_s1;
    logic sdo_s2;
    logic [CNT_W-1:0] cnt;
    logic [2:0] bitc;
    logic [7:0] txsr;
    logic [7:0] rxsr;
    logic last;
    logic [7:0] op;
    logic pd;
    logic udpd;
    logic rx_valid;
    logic [7:0] rx_data;
  } mst_st_t;

  mst_st_t s;
  mst_st_t next_s;
  logic tick;
  logic [CNT_W-1:0] half;

  // Half period of the serial clock for the chosen rate
  always_comb
  begin
    unique case (rate_sel)
      RATE_FAST: half = CNT_W'(HALF_FAST - 1);
      RATE_AUTO_PD: half = CNT_W'(HALF_APD - 1);
      default: half = CNT_W'(HALF_NORMAL - 1);
    endcase
  end

  assign tick = (s.cnt == '0);
  // Byte taken at frame start or after the last bit of a byte
  assign tx_ready = tx_valid && !s.held && (((s.st == M_IDLE) && !s.udpd)
    || ((s.st == M_HIGH) && tick && (s.bitc == 3'h7) && !s.last));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.rx_valid = 1'h0;
    next_s.sdo_s1 = link.sdo;
    next_s.sdo_s2 = s.sdo_s1;
    // Hold is raised only inside a low phase, never on its last cycle
    if (!hold_req)
    begin
      next_s.held = 1'h0;
      if (s.held)
      begin
        next_s.cnt = half; // Full low phase so the output settles again
      end
    end
    else if ((s.st == M_LOW) && !tick)
    begin
      next_s.held = 1'h1;
    end
    if (!tick && !(s.held && s.st == M_LOW))
    begin
      next_s.cnt = s.cnt - 1'h1;
    end
    unique case (s.st)
      M_IDLE:
      begin
        next_s.sck = mode3;
        next_s.sel = 1'h0;
        next_s.sdi = 1'h0;
        if (tx_valid && s.udpd)
        begin
          next_s.st = M_WAKE;
          next_s.sel = 1'h1;
          next_s.cnt = CNT_W'(CS_MIN_CYC - 1);
        end
        else if (tx_ready)
        begin
          next_s.st = M_SETUP;
          next_s.sel = 1'h1;
          next_s.op = tx_data;
          next_s.txsr = tx_data;
          next_s.sdi = tx_data[7];
          next_s.last = tx_last;
          next_s.bitc = 3'h0;
          next_s.cnt = half;
        end
      end
      M_WAKE:
      begin
        if (tick)
        begin
          next_s.sel = 1'h0;
          next_s.udpd = 1'h0;
          next_s.st = M_GUARD;
          next_s.cnt = CNT_W'(DEEP_EXIT_CYCLES - 1);
        end
      end
      M_GUARD:
      begin
        if (tick)
        begin
          next_s.st = M_IDLE;
        end
      end
      M_SETUP:
      begin
        if (tick)
        begin
          next_s.st = M_LOW;
          next_s.sck = 1'h0;
          next_s.cnt = half;
        end
      end
      M_LOW:
      begin
        if (tick && !s.held)
        begin
          next_s.st = M_HIGH;
          next_s.sck = 1'h1;
          next_s.rxsr = {s.rxsr[6:0], s.sdo_s2};
          next_s.cnt = half;
        end
      end
      M_HIGH:
      begin
        if (tick && s.bitc != 3'h7)
        begin
          next_s.bitc = s.bitc + 3'h1;
          next_s.sdi = s.txsr[6];
          next_s.txsr = {s.txsr[6:0], 1'h0};
          next_s.sck = 1'h0;
          next_s.st = M_LOW;
          next_s.cnt = half;
        end
        else if (tick && s.last)
        begin
          next_s.rx_valid = 1'h1;
          next_s.rx_data = s.rxsr;
          next_s.sck = mode3;
          next_s.st = M_END;
          next_s.cnt = half;
        end
        else if (tx_ready)
        begin
          next_s.rx_valid = 1'h1;
          next_s.rx_data = s.rxsr;
          next_s.txsr = tx_data;
          next_s.sdi = tx_data[7];
          next_s.last = tx_last;
          next_s.bitc = 3'h0;
          next_s.sck = 1'h0;
          next_s.st = M_LOW;
          next_s.cnt = half;
        end
      end
      M_END:
      begin
        if (tick)
        begin
          next_s.sel = 1'h0;
          next_s.st = M_GAP;
          next_s.cnt = CNT_W'(CS_MIN_CYC - 1);
          if (s.op == OP_DEEP_DOWN)
          begin
            next_s.udpd = 1'h1;
          end
          if (s.op == OP_POWER_DOWN)
          begin
            next_s.pd = 1'h1;
          end
          if (s.op == OP_RESUME)
          begin
            next_s.pd = 1'h0;
            next_s.cnt = CNT_W'(RESUME_CYCLES - 1);
          end
        end
      end
      M_GAP:
      begin
        if (tick)
        begin
          next_s.st = M_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.cs_n = !s.sel;
  assign link.sck = s.sck;
  assign link.sdi = s.sdi;
  assign link.hold_n = !s.held;
  assign rx_valid = s.rx_valid;
  assign rx_data = s.rx_data;
  assign idle = (s.st == M_IDLE);

endmodule

// >>> testbench/spi_mem_link_props.sv
// Concurrent checks on the serial memory link signals
`timescale 1ns/10ps
module spi_mem_link_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Master driven lines
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic hold_n,
  // Device output pin pieces
  input wire logic sdo_o,
  input wire logic sdo_oe_n,
  input wire logic sdo_pu
);
  import spi_mem_pkg::*;
  typedef struct packed {logic sck_q; logic [7:0] run;} watch_t;
  watch_t st;
  watch_t next_st;

  // Cycles since the link clock last moved, saturating
  always_comb
  begin
    next_st = st;
    next_st.sck_q = sck;
    if (sck != st.sck_q)
      next_st.run = 8'h00;
    else if (st.run != 8'hff)
      next_st.run = st.run + 8'h01;
  end

  // Helper state register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------
  // Link assertions
  // ------------------------------------------------------------
  park_hold_a: assert property ($rose(cs_n) |-> $stable(sck) [*6])
    else $error("link clock moved after deselect");
  sel_setup_a: assert property ($fell(cs_n) |=> $stable(sck) [*8])
    else $error("link clock moved right after select");
  deselect_float_a: assert property (cs_n [*6] |-> sdo_oe_n)
    else $error("output driven while deselected");
  fall_shift_a: assert property ($changed(sdo_o) && !sdo_oe_n |-> !sck)
    else $error("output changed outside clock low phase");
  rise_stable_a: assert property ($rose(sck) && !cs_n |->
    sdi == $past(sdi, 3) ##1 $stable(sdi) [*3])
    else $error("input data moved around clock rise");
  hold_low_a: assert property (!hold_n |-> !sck && !cs_n)
    else $error("pause outside a clock low phase");
  hold_float_a: assert property ($fell(hold_n) |-> ##[0:5] sdo_oe_n)
    else $error("output still driven during pause");
  pullup_idle_a: assert property (sdo_pu |-> sdo_oe_n)
    else $error("pull-up on while output driven");
  sck_rate_a: assert property ($changed(sck) && !cs_n |->
    st.run >= HALF_FAST - 1)
    else $error("link clock phase too short");
endmodule

// >>> testbench/test_spi_serial_memory_interface.sv
// Self-checking bench joining master and device ends of the link
`timescale 1ns/10ps
module test_spi_serial_memory_interface;
  import spi_mem_pkg::*;
  localparam int BYTE_CYC = 20;
  localparam int PAGE_CYC = 1500;
  localparam int LIMIT = 90000;
  logic mclk, rst_n, mode3, hold_req, tx_valid, tx_last, tx_ready, idle;
  logic m_rx_valid, d_rx_valid, rx_first, tx_req, write_busy_flag, active;
  logic standby, power_down, deep_power_down, frame_end, frame_abort;
  logic saw_end, saw_active, saw_abort;
  rate_t rate_sel;
  logic [7:0] m_tx_data, m_rx_data, d_tx_data, d_rx_data, nb, rd_op;
  logic [7:1] status_upper;
  logic [8:0] drx[$];
  logic [7:0] mrx[$], rdq[$], fb[$];
  int failures = 0, checks_done = 0, cycles = 0;
  int busy_run = 0, busy_len = 0, wr_len, rd_at;

  spi_mem_if link();
  spi_mem_master #(.RESUME_CYCLES(40), .DEEP_EXIT_CYCLES(40))
    i_spi_mem_master (.mclk(mclk), .rst_n(rst_n), .link(link), .mode3(mode3),
    .rate_sel(rate_sel), .hold_req(hold_req), .tx_valid(tx_valid),
    .tx_data(m_tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .rx_valid(m_rx_valid), .rx_data(m_rx_data), .idle(idle));
  spi_mem_device #(.BYTE_WR_CYCLES(BYTE_CYC), .PAGE_WR_CYCLES(PAGE_CYC))
    i_spi_mem_device (.mclk(mclk), .rst_n(rst_n), .link(link),
    .rx_valid(d_rx_valid), .rx_data(d_rx_data), .rx_first(rx_first),
    .tx_req(tx_req), .tx_data(d_tx_data), .status_upper(status_upper),
    .write_busy_flag(write_busy_flag), .active(active), .standby(standby),
    .power_down(power_down), .deep_power_down(deep_power_down),
    .frame_end(frame_end), .frame_abort(frame_abort));
  spi_mem_link_props i_spi_mem_link_props (.mclk(mclk), .rst_n(rst_n),
    .cs_n(link.cs_n), .sck(link.sck), .sdi(link.sdi), .hold_n(link.hold_n),
    .sdo_o(link.sdo_o), .sdo_oe_n(link.sdo_oe_n), .sdo_pu(link.sdo_pu));

  // Clock generator
  initial
  begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end

  // Monitors, read data supply and cycle limit
  always @(posedge mclk)
  begin
    cycles++;
    if (d_rx_valid === 1'h1)
      drx.push_back({rx_first, d_rx_data});
    if (m_rx_valid === 1'h1)
      mrx.push_back(m_rx_data);
    if (active === 1'h1)
      saw_active = 1'h1;
    if (frame_end === 1'h1)
      saw_end = 1'h1;
    if (frame_abort === 1'h1)
      saw_abort = 1'h1;
    if (write_busy_flag === 1'h1)
      busy_run++;
    else if (busy_run != 0)
    begin
      busy_len = busy_run;
      busy_run = 0;
    end
    if (tx_req === 1'h1)
    begin
      nb = 8'($urandom);
      rdq.push_back(nb);
      d_tx_data <= #1 nb;
    end
    if (cycles == LIMIT)
    begin
      failures++;
      results();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      failures++;
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Sends one frame and compares both ends with the byte model
  task automatic frame(input logic [7:0] b[$], input logic to_dev);
    int n;
    drx.delete();
    mrx.delete();
    rdq.delete();
    saw_end = 1'h0;
    saw_active = 1'h0;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < b.size(); i++)
    begin
      #1 tx_valid = 1'h1;
      m_tx_data = b[i];
      tx_last = (i == b.size() - 1);
      n = 0;
      @(negedge mclk);
      while (tx_ready !== 1'h1 && n < 30000)
      begin
        @(negedge mclk);
        n++;
      end
      @(posedge mclk);
    end
    #1 tx_valid = 1'h0;
    n = 0;
    repeat (3) @(posedge mclk);
    while (idle !== 1'h1 && n < 30000)
    begin
      @(posedge mclk);
      n++;
    end
    repeat (4) @(posedge mclk);
    check(mrx.size(), b.size());
    check(saw_end, 1'h1);
    check(saw_active, 1'h1);
    check(drx.size(), to_dev ? b.size() : 0);
    for (int i = 0; i < drx.size(); i++)
      check(drx[i], {i == 0, b[i]});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst_n = 1'h0;
    {mode3, hold_req, tx_valid, tx_last, saw_abort} = 5'h00;
    rate_sel = RATE_FAST;
    {m_tx_data, status_upper} = 15'h0;
    void'($urandom(32'h88fc4532));
    repeat (5) @(posedge mclk);
    #1 rst_n = 1'h1;
    repeat (3) @(posedge mclk);
    check({link.sdo_oe_n, link.sdo_pu}, 2'h2);
    // Status reads in both modes at every rate
    for (int m = 0; m < 2; m++)
      for (int r = 0; r < 3; r++)
      begin
        #1 mode3 = m[0];
        rate_sel = rate_t'(r);
        status_upper = 7'($urandom);
        frame({OP_READ_STATUS, 8'($urandom)}, 1'h1);
        check(mrx[1], {status_upper, 1'h0});
        check(standby, 1'h1);
      end
    $display("test modes and rates done");
    // Array, fast and one-time area reads with a pause mid-frame
    #1 rate_sel = RATE_FAST;
    for (int k = 0; k < 3; k++)
    begin
      rd_op = k == 0 ? OP_READ : (k == 1 ? OP_FAST_READ : OP_READ_OTP);
      rd_at = k == 0 ? 3 : (k == 1 ? 4 : 1);
      fork
        frame({rd_op, 8'($urandom), 8'($urandom), 8'h00, 8'h00, 8'h00},
          1'h1);
        begin
          repeat (300) @(posedge mclk);
          #1 hold_req = 1'h1;
          repeat (200) @(posedge mclk);
          #1 hold_req = 1'h0;
        end
      join
      for (int j = rd_at; j < 6; j++)
        check(mrx[j], rdq[j - rd_at]);
    end
    $display("test reads with pause done");
    // Writes and erases: busy length and live busy bit
    for (int k = 0; k < 5; k++)
    begin
      wr_len = k == 0 ? BYTE_CYC : PAGE_CYC;
      busy_len = 0;
      case (k)
        0: fb = {OP_WRITE, 8'h00, 8'h10, 8'($urandom)};
        1: fb = {OP_WRITE, 8'h00, 8'h20, 8'h5a, 8'ha5};
        2: fb = {OP_PAGE_ERASE, 8'h00, 8'h40};
        3: fb = {OP_CHIP_ERASE};
        default: fb = {OP_CHIP_ERASE_ALT};
      endcase
      frame(fb, 1'h1);
      if (k != 0)
      begin
        frame({OP_READ_STATUS, 8'h00}, 1'h1);
        check(mrx[1][0], 1'h1);
      end
      repeat (PAGE_CYC) @(posedge mclk);
      check(busy_len >= wr_len && busy_len <= wr_len + 2, 1'h1);
      check(standby, 1'h1);
    end
    $display("test writes done");
    // Power-down, resume, deep power-down and wake-up
    frame({OP_POWER_DOWN}, 1'h1);
    check(power_down, 1'h1);
    frame({OP_READ_STATUS, 8'h00}, 1'h0);
    frame({OP_RESUME}, 1'h0);
    check(power_down, 1'h0);
    frame({OP_DEEP_DOWN}, 1'h1);
    check(deep_power_down, 1'h1);
    check({link.sdo_pu, link.sdo}, 2'h3);
    frame({OP_READ_STATUS, 8'h00}, 1'h1);
    check(mrx[1], {status_upper, 1'h0});
    check({link.sdo_oe_n, link.sdo_pu}, 2'h2);
    check(saw_abort, 1'h0);
    $display("test power states done");
    results();
  end
endmodule
